//--- rtl/sac_top.sv
`timescale 1ns/10ps
`include "sac_consts.svh"

// Summary of operation
// - code 0000 takes bit and word clock from the pins, none generated.
// - codes 0001-0111 and 1100 divide the audio clock by 24..2.
// - codes 1000-1010 follow port 1, 2 or 3 clocks; 1011 reserved.
// - bit 11 set holds transmit FIFO reset and empty, with the output sample forced to zero.
// - bits 16,10:8 pick transmit data source; 0110 reserved.
// - bits 7:6 pick 16, 18 or 20 bit words, or forced zero.
// - bit 5 selects right-justified framing when set, I2S when clear.
// - bits 4:2 give 64, 48 or 32 bit clocks per word clock.
// - bit 1 inverts the word clock seen by serial logic.
// - bit 0 inverts the bit clock seen by serial logic.
// - bit 17 samples correction flag 1 after or 6 before word edge.
// - three 32-bit RW registers at 0x14, 0x18, 0x1c, reset 0x0fc8.
// - port 1 flag insert mode puts error and correction flags in low bits.
// - after hold clears, FIFO stays reset until the first word is written.
// - third register (0x1c, port 4) only uses its bit clock setting.
module sac_top
   import sac_pkg::*;
#(
   parameter int W     = `SAC_SAMPLE_W,
   parameter int DEPTH = `SAC_FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         audio_clk,
   input  wire logic         p1_bit_clock,
   input  wire logic         p1_word_clock,
   input  wire logic         p2_bit_clock_in,
   output logic              p2_bit_clock_out,
   output logic              p2_bit_clock_oe,
   input  wire logic         p2_word_clock_in,
   output logic              p2_word_clock_out,
   output logic              p2_word_clock_oe,
   input  wire logic         p3_bit_clock_in,
   output logic              p3_bit_clock_out,
   output logic              p3_bit_clock_oe,
   input  wire logic         p3_word_clock_in,
   output logic              p3_word_clock_out,
   output logic              p3_word_clock_oe,
   input  wire logic         adc_bit_clock_in,
   output logic              adc_bit_clock_out,
   output logic              adc_bit_clock_oe,
   output logic              p2_serial_bclk,
   output logic              p2_serial_wclk,
   output logic              p3_serial_bclk,
   output logic              p3_serial_wclk,
   output logic              p2_right_justified_format,
   output logic              p3_right_justified_format,
   output logic      [6:0]   p2_frame_bits,
   output logic      [6:0]   p3_frame_bits,
   output logic              p3_correction_flag_input_early,
   input  wire logic         p1_error_flag_insert,
   input  wire logic         p1_correction_flag_input_early,
   input  wire logic         correction_flag_input,
   input  wire logic         error_flag_input,
   input  wire logic [W-1:0] cpu_audio_out_1,
   input  wire logic [W-1:0] cpu_audio_out_2,
   input  wire logic [W-1:0] cpu_audio_out_3,
   input  wire logic [W-1:0] port1_rx_data,
   input  wire logic [W-1:0] port3_rx_data,
   input  wire logic [W-1:0] spdif_rx1_data,
   input  wire logic [W-1:0] spdif_rx2_data,
   input  wire logic [6:0]   src_valid,
   output logic              src_ready,
   output logic      [W-1:0] tx_sample,
   output logic              tx_sample_strobe
);
   import sac_pkg::*;

   localparam int NSYNC = 10;
   localparam int HALF  = W / 2;

   // ---------------- input synchronisers ----------------
   logic [NSYNC-1:0] pin_raw, s1_q, s2_q;
   logic             audio_q3, audio_tick;
   logic             p1_bclk_q3, p1_wclk_q3;

   assign pin_raw = {error_flag_input, correction_flag_input, p1_word_clock, p1_bit_clock,
                     adc_bit_clock_in, p3_word_clock_in, p3_bit_clock_in,
                     p2_word_clock_in, p2_bit_clock_in, audio_clk};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= pin_raw[g];
               s2_q[g] <= s1_q[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         audio_q3   <= 1'b0;
         p1_bclk_q3 <= 1'b0;
         p1_wclk_q3 <= 1'b0;
      end else begin
         audio_q3   <= s2_q[0];
         p1_bclk_q3 <= s2_q[6];
         p1_wclk_q3 <= s2_q[7];
      end
   end
   assign audio_tick = s2_q[0] & ~audio_q3;

   // ---------------- APB slave, one wait state ----------------
   logic [31:0] cfg_q [3];
   logic [31:0] cfg_d [3];
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d, hit, wr_fire;
   logic [1:0]  idx;

   always_comb begin
      hit = 1'b1;
      idx = 2'd0;
      if (paddr == `SAC_OFF_PORT2) idx = 2'd0;
      else if (paddr == `SAC_OFF_PORT3) idx = 2'd1;
      else if (paddr == `SAC_OFF_PORT4) idx = 2'd2;
      else hit = 1'b0;
   end

   assign wr_fire = psel & penable & pready & pwrite & hit;

   always_comb begin
      pready_d  = psel & penable & ~pready;
      pslverr_d = pready_d & ~hit;
      prdata_d  = 32'h0000_0000;
      if (pready_d && !pwrite && hit) prdata_d = cfg_q[idx];
      for (int i = 0; i < 3; i++) begin
         cfg_d[i] = cfg_q[i];
         if (wr_fire && idx == 2'(i)) cfg_d[i] = pwdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < 3; i++) cfg_q[i] <= `SAC_CFG_RESET;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         for (int i = 0; i < 3; i++) cfg_q[i] <= cfg_d[i];
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   // ---------------- clock selection per port ----------------
   logic [2:0] eff_bclk_q, eff_wclk_q, ser_bclk_q, ser_wclk_q;
   logic [2:0] bclk_oe_q, wclk_oe_q, gen_bclk, gen_wclk;
   logic [2:0] ext_bclk, ext_wclk;

   assign ext_bclk = {s2_q[5], s2_q[3], s2_q[1]};
   assign ext_wclk = {1'b0, s2_q[4], s2_q[2]};

   function automatic logic [4:0] clk_div(input logic [3:0] sel);
      case (sel)
         `SAC_CLK_DIV24: clk_div = 5'd24;
         `SAC_CLK_DIV16: clk_div = 5'd16;
         `SAC_CLK_DIV12: clk_div = 5'd12;
         `SAC_CLK_DIV8:  clk_div = 5'd8;
         `SAC_CLK_DIV6:  clk_div = 5'd6;
         `SAC_CLK_DIV4:  clk_div = 5'd4;
         `SAC_CLK_DIV3:  clk_div = 5'd3;
         `SAC_CLK_DIV2:  clk_div = 5'd2;
         default:        clk_div = 5'd0;
      endcase
   endfunction

   function automatic logic [6:0] frame_len(input logic [2:0] code);
      case (code)
         `SAC_FRAME_64: frame_len = 7'd64;
         `SAC_FRAME_48: frame_len = 7'd48;
         default:       frame_len = 7'd32; // reserved codes run as 32
      endcase
   endfunction

   generate
      for (g = 0; g < 3; g++) begin : g_port
         logic [3:0]    sel;
         logic [6:0]    flen;
         sac_clk_mode_t mode;
         logic          bclk_d, wclk_d;

         assign sel  = cfg_q[g][`SAC_CLKSEL_MSB:`SAC_CLKSEL_LSB];
         // port 4 ignores frame length and inversion
         assign flen = (g == 2) ? 7'd32 : frame_len(cfg_q[g][`SAC_FRAME_MSB:`SAC_FRAME_LSB]);

         always_comb begin
            if (sel == `SAC_CLK_INPUT) mode = CM_INPUT;
            else if (clk_div(sel) != 5'd0) mode = CM_DIVIDE;
            else if (sel == `SAC_CLK_RESERVED) mode = CM_RESERVED;
            else mode = CM_FOLLOW;
         end

         sac_clk_div u_div (
            .clk        (clk),
            .srst       (srst),
            .audio_tick (audio_tick),
            .div        (clk_div(sel)),
            .frame_bits (flen),
            .bclk_q     (gen_bclk[g]),
            .wclk_q     (gen_wclk[g])
         );

         always_comb begin
            bclk_d = 1'b0;
            wclk_d = 1'b0;
            case (mode)
               CM_INPUT: begin
                  bclk_d = ext_bclk[g];
                  wclk_d = ext_wclk[g];
               end
               CM_DIVIDE: begin
                  bclk_d = gen_bclk[g];
                  wclk_d = gen_wclk[g];
               end
               CM_FOLLOW: begin
                  // followed clocks come from registers, so mutual follows cannot loop
                  if (sel == `SAC_CLK_FOLLOW1) begin
                     bclk_d = p1_bclk_q3;
                     wclk_d = p1_wclk_q3;
                  end else if (sel == `SAC_CLK_FOLLOW2) begin
                     bclk_d = eff_bclk_q[0];
                     wclk_d = eff_wclk_q[0];
                  end else begin
                     bclk_d = eff_bclk_q[1];
                     wclk_d = eff_wclk_q[1];
                  end
               end
               default: begin
                  bclk_d = 1'b0;
                  wclk_d = 1'b0;
               end
            endcase
         end

         always_ff @(posedge clk) begin
            if (srst) begin
               eff_bclk_q[g] <= 1'b0;
               eff_wclk_q[g] <= 1'b0;
               ser_bclk_q[g] <= 1'b0;
               ser_wclk_q[g] <= 1'b0;
               bclk_oe_q[g]  <= 1'b0;
               wclk_oe_q[g]  <= 1'b0;
            end else begin
               eff_bclk_q[g] <= bclk_d;
               eff_wclk_q[g] <= wclk_d;
               ser_bclk_q[g] <= bclk_d ^ (cfg_q[g][`SAC_BCLK_INV_BIT] && g != 2);
               ser_wclk_q[g] <= wclk_d ^ (cfg_q[g][`SAC_WCLK_INV_BIT] && g != 2);
               bclk_oe_q[g]  <= (mode == CM_DIVIDE) || (mode == CM_FOLLOW);
               wclk_oe_q[g]  <= ((mode == CM_DIVIDE) || (mode == CM_FOLLOW)) && g != 2;
            end
         end
      end
   endgenerate

   assign p2_bit_clock_out  = eff_bclk_q[0];
   assign p2_bit_clock_oe   = bclk_oe_q[0];
   assign p2_word_clock_out = eff_wclk_q[0];
   assign p2_word_clock_oe  = wclk_oe_q[0];
   assign p3_bit_clock_out  = eff_bclk_q[1];
   assign p3_bit_clock_oe   = bclk_oe_q[1];
   assign p3_word_clock_out = eff_wclk_q[1];
   assign p3_word_clock_oe  = wclk_oe_q[1];
   assign adc_bit_clock_out = eff_bclk_q[2];
   assign adc_bit_clock_oe  = bclk_oe_q[2];
   assign p2_serial_bclk    = ser_bclk_q[0];
   assign p2_serial_wclk    = ser_wclk_q[0];
   assign p3_serial_bclk    = ser_bclk_q[1];
   assign p3_serial_wclk    = ser_wclk_q[1];
   assign p2_right_justified_format = cfg_q[0][`SAC_FORMAT_BIT];
   assign p3_right_justified_format = cfg_q[1][`SAC_FORMAT_BIT];
   assign p3_correction_flag_input_early     = cfg_q[1][`SAC_CORRECTION_FLAG_INPUT_POS_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         p2_frame_bits <= 7'd32;
         p3_frame_bits <= 7'd32;
      end else begin
         p2_frame_bits <= frame_len(cfg_q[0][`SAC_FRAME_MSB:`SAC_FRAME_LSB]);
         p3_frame_bits <= frame_len(cfg_q[1][`SAC_FRAME_MSB:`SAC_FRAME_LSB]);
      end
   end

   // ---------------- port 1 flag capture and insertion ----------------
   logic [7:0] p1_bit_q, p1_bit_d, p1_per_q, p1_per_d;
   logic       ef_q, ef_d, cf_q, cf_d, p1_rise;
   logic [W-1:0] p1_word;

   assign p1_rise = s2_q[6] & ~p1_bclk_q3;

   always_comb begin
      p1_bit_d = p1_bit_q;
      p1_per_d = p1_per_q;
      ef_d     = ef_q;
      cf_d     = cf_q;
      if (s2_q[7] != p1_wclk_q3) begin
         p1_bit_d = 8'h00;
         p1_per_d = p1_bit_q;
      end else if (p1_rise) begin
         p1_bit_d = p1_bit_q + 8'h01;
         if ((!p1_correction_flag_input_early && p1_bit_d == `SAC_CORRECTION_FLAG_INPUT_AFTER) ||
             (p1_correction_flag_input_early && p1_bit_d == p1_per_q - `SAC_CORRECTION_FLAG_INPUT_BEFORE)) begin
            cf_d = s2_q[8];
            ef_d = s2_q[9];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         p1_bit_q <= 8'h00;
         p1_per_q <= 8'h00;
         ef_q     <= 1'b0;
         cf_q     <= 1'b0;
      end else begin
         p1_bit_q <= p1_bit_d;
         p1_per_q <= p1_per_d;
         ef_q     <= ef_d;
         cf_q     <= cf_d;
      end
   end

   // 16 MSBs of each channel move to bits 17:2, flags fill bits 1:0
   assign p1_word = p1_error_flag_insert ?
      {2'b00, port1_rx_data[W-1 -: 16], ef_q, cf_q,
       2'b00, port1_rx_data[HALF-1 -: 16], ef_q, cf_q} : port1_rx_data;

   // ---------------- port 2 transmit path ----------------
   logic [3:0]   src_sel;
   logic [W-1:0] src_data, fifo_out, sample_d, tx_sample_d;
   logic         src_vld, fifo_in_ready, fifo_out_valid, frame_tick;
   logic         hold_q, hold_d, flush, push, strobe_d;
   logic [1:0]   size;

   assign src_sel = {cfg_q[0][`SAC_TXSRC_HI_BIT], cfg_q[0][`SAC_TXSRC_MSB:`SAC_TXSRC_LSB]};
   assign size    = cfg_q[0][`SAC_SIZE_MSB:`SAC_SIZE_LSB];

   always_comb begin
      src_data = '0;
      src_vld  = 1'b0;
      case (src_sel)
         `SAC_SRC_CPU1:     begin src_data = cpu_audio_out_1; src_vld = src_valid[0]; end
         `SAC_SRC_CPU2:     begin src_data = cpu_audio_out_2; src_vld = src_valid[1]; end
         `SAC_SRC_CPU3:     begin src_data = cpu_audio_out_3; src_vld = src_valid[2]; end
         `SAC_SRC_PORT1_RX: begin src_data = p1_word;         src_vld = src_valid[3]; end
         `SAC_SRC_PORT3_RX: begin src_data = port3_rx_data;   src_vld = src_valid[4]; end
         `SAC_SRC_SPDIF1:   begin src_data = spdif_rx1_data;  src_vld = src_valid[5]; end
         `SAC_SRC_SPDIF2:   begin src_data = spdif_rx2_data;  src_vld = src_valid[6]; end
         default:           begin src_data = '0;              src_vld = 1'b0;         end
      endcase
   end

   // hold releases only on the first accepted word so streaming starts with it
   assign push   = src_vld & src_ready;
   assign hold_d = cfg_q[0][`SAC_TXHOLD_BIT] | (hold_q & ~push);
   assign flush  = hold_q & ~push;

   // a new sample is due at each rising edge of the port 2 word clock before inversion
   assign frame_tick = g_port[0].wclk_d & ~eff_wclk_q[0];

   sac_fifo #(
      .WIDTH (W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .flush     (flush),
      .in_data   (src_data),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (frame_tick & ~hold_q)
   );

   always_comb begin
      sample_d = fifo_out;
      if (size == `SAC_SIZE_16) begin
         sample_d[HALF+3:HALF] = 4'h0;
         sample_d[3:0]         = 4'h0;
      end else if (size == `SAC_SIZE_18) begin
         sample_d[HALF+1:HALF] = 2'h0;
         sample_d[1:0]         = 2'h0;
      end
      tx_sample_d = tx_sample;
      strobe_d    = frame_tick;
      if (hold_q) tx_sample_d = '0;
      else if (frame_tick) begin
         if (src_sel == `SAC_SRC_ZERO || size == `SAC_SIZE_ZERO) tx_sample_d = '0;
         else if (fifo_out_valid) tx_sample_d = sample_d;
         // underrun repeats the last sample
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hold_q           <= 1'b1;
         tx_sample        <= '0;
         tx_sample_strobe <= 1'b0;
         src_ready        <= 1'b0;
      end else begin
         hold_q           <= hold_d;
         tx_sample        <= tx_sample_d;
         tx_sample_strobe <= strobe_d;
         // registered ready cannot see the count ahead, so it rests a cycle after a push
         src_ready        <= fifo_in_ready & ~push & ~cfg_d[0][`SAC_TXHOLD_BIT];
      end
   end
endmodule

//--- rtl/sac_consts.svh
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register byte offsets
`define SAC_OFF_PORT2        8'h14
`define SAC_OFF_PORT3        8'h18
`define SAC_OFF_PORT4        8'h1c
`define SAC_CFG_RESET        32'h0000_0fc8

// field positions
`define SAC_FLAG_INSERT_BIT  18
`define SAC_CORRECTION_FLAG_INPUT_POS_BIT     17
`define SAC_TXSRC_HI_BIT     16
`define SAC_CLKSEL_MSB       15
`define SAC_CLKSEL_LSB       12
`define SAC_TXHOLD_BIT       11
`define SAC_TXSRC_MSB        10
`define SAC_TXSRC_LSB        8
`define SAC_SIZE_MSB         7
`define SAC_SIZE_LSB         6
`define SAC_FORMAT_BIT       5
`define SAC_FRAME_MSB        4
`define SAC_FRAME_LSB        2
`define SAC_WCLK_INV_BIT     1
`define SAC_BCLK_INV_BIT     0

// bit clock source codes
`define SAC_CLK_INPUT        4'h0
`define SAC_CLK_DIV24        4'h1
`define SAC_CLK_DIV16        4'h2
`define SAC_CLK_DIV12        4'h3
`define SAC_CLK_DIV8         4'h4
`define SAC_CLK_DIV6         4'h5
`define SAC_CLK_DIV4         4'h6
`define SAC_CLK_DIV3         4'h7
`define SAC_CLK_FOLLOW1      4'h8
`define SAC_CLK_FOLLOW2      4'h9
`define SAC_CLK_FOLLOW3      4'ha
`define SAC_CLK_RESERVED     4'hb
`define SAC_CLK_DIV2         4'hc

// transmit source codes
`define SAC_SRC_ZERO         4'h0
`define SAC_SRC_CPU1         4'h1
`define SAC_SRC_CPU2         4'h2
`define SAC_SRC_CPU3         4'h3
`define SAC_SRC_PORT1_RX     4'h4
`define SAC_SRC_PORT3_RX     4'h5
`define SAC_SRC_SPDIF1       4'h7
`define SAC_SRC_SPDIF2       4'h8

// word size and frame length codes
`define SAC_SIZE_16          2'h0
`define SAC_SIZE_18          2'h1
`define SAC_SIZE_20          2'h2
`define SAC_SIZE_ZERO        2'h3
`define SAC_FRAME_64         3'h4
`define SAC_FRAME_48         3'h2
`define SAC_FRAME_32         3'h0

// correction flag sample points, in bit clocks
`define SAC_CORRECTION_FLAG_INPUT_AFTER       8'h01
`define SAC_CORRECTION_FLAG_INPUT_BEFORE      8'h06

`define SAC_SAMPLE_W         40
`define SAC_FIFO_DEPTH       8

`endif

//--- rtl/sac_pkg.sv
package sac_pkg;
   typedef enum logic [1:0] {
      CM_INPUT,
      CM_DIVIDE,
      CM_FOLLOW,
      CM_RESERVED
   } sac_clk_mode_t;
endpackage

//--- rtl/sac_fifo.sv
`timescale 1ns/10ps
module sac_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (flush) begin
         wr_d  = '0;
         rd_d  = '0;
         cnt_d = '0;
      end else begin
         if (push) wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)  rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage needs no reset; empty flag guards stale words
   always_ff @(posedge clk) begin
      if (push && !flush) mem_q[wr_q] <= in_data;
   end
endmodule

//--- rtl/sac_clk_div.sv
`timescale 1ns/10ps
module sac_clk_div (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       audio_tick,
   input  wire logic [4:0] div,
   input  wire logic [6:0] frame_bits,
   output logic            bclk_q,
   output logic            wclk_q
);
   logic [4:0] cnt_q, cnt_d;
   logic [5:0] bit_q, bit_d;
   logic       bclk_d, wclk_d;

   // uneven divisors give a short high phase, within the allowed mark/space
   always_comb begin
      cnt_d  = cnt_q;
      bit_d  = bit_q;
      wclk_d = wclk_q;
      if (audio_tick && div != 5'h00) begin
         cnt_d = (cnt_q >= div - 5'h01) ? 5'h00 : cnt_q + 5'h01;
      end
      bclk_d = (div != 5'h00) && (cnt_d < (div >> 1));
      if (bclk_q && !bclk_d) begin
         if (bit_q >= frame_bits[6:1] - 6'h01) begin
            bit_d  = 6'h00;
            wclk_d = ~wclk_q;
         end else begin
            bit_d = bit_q + 6'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q  <= 5'h00;
         bit_q  <= 6'h00;
         bclk_q <= 1'b0;
         wclk_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         bit_q  <= bit_d;
         bclk_q <= bclk_d;
         wclk_q <= wclk_d;
      end
   end
endmodule

//--- verification/sac_chk.sv
`timescale 1ns/10ps
module sac_chk #(parameter int W = 40) (
   input wire logic         clk,
   input wire logic         srst,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [7:0]   paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic         p2_bit_clock_oe,
   input wire logic         p2_right_justified_format,
   input wire logic [6:0]   p2_frame_bits,
   input wire logic         src_ready,
   input wire logic [W-1:0] tx_sample,
   input wire logic         tx_sample_strobe
);
   logic [31:0] c_q, c_d;
   logic [3:0]  age_q, age_d;
   logic        ok;
   // shadow of the port 2 setup; checks wait until the pin path has settled
   always_comb begin
      c_d = c_q;
      age_d = age_q + {3'h0, age_q != 4'hf};
      if (psel && penable && pready && pwrite && paddr == 8'h14) begin
         c_d = pwdata;
         age_d = 4'h0;
      end
   end
   always_ff @(posedge clk) begin
      c_q <= srst ? 32'h0000_0fc8 : c_d;
      age_q <= srst ? 4'h0 : age_d;
   end
   assign ok = age_q > 4'h7;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence setup_s; psel && !penable; endsequence
   sequence wait_s; psel && penable && !pready; endsequence
   bus_answer_a:
      assert property (setup_s ##1 wait_s |=> pready) else $error("late answer");
   unmapped_err_a:
      assert property (pready && !(paddr inside {8'h14, 8'h18, 8'h1c}) |-> pslverr &&
         prdata == 32'h0000_0000) else $error("unmapped access");
   pin_input_a:
      assert property (ok && c_q[15:12] == 4'h0 |-> !p2_bit_clock_oe) else $error("pin driven");
   rj_format_a:
      assert property (ok |-> p2_right_justified_format == c_q[5]) else $error("format");
   frame_len_a:
      assert property (ok |-> p2_frame_bits == (c_q[4:2] == 3'h4 ? 7'h40 :
         c_q[4:2] == 3'h2 ? 7'h30 : 7'h20)) else $error("frame length");
   fifo_hold_a:
      assert property (ok && c_q[11] |-> !src_ready && tx_sample == '0) else $error("hold");
   zero_data_a:
      assert property (tx_sample_strobe && ok && (c_q[7:6] == 2'h3 ||
         {c_q[16], c_q[10:8]} == 4'h0) |-> tx_sample == '0) else $error("zero data");
   pad_16_a:
      assert property (tx_sample_strobe && ok && c_q[7:6] == 2'h0 |->
         tx_sample[23:20] == 4'h0 && tx_sample[3:0] == 4'h0) else $error("padding");
endmodule
bind sac_top sac_chk #(.W(W)) i_sac_chk (.clk, .srst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .p2_bit_clock_oe, .p2_right_justified_format,
   .p2_frame_bits, .src_ready, .tx_sample, .tx_sample_strobe);

//--- verification/sac_conv_model.sv
`timescale 1ns/10ps
module sac_conv_model (
   input  wire logic clk,
   input  wire logic run,
   output logic      bit_clock,
   output logic      word_clock
);
   logic [7:0] n_q = 8'h00;
   // clock master converter, frozen while idle so no frame tick leaks out
   always @(posedge clk) if (run) n_q <= n_q + 8'h01;
   assign bit_clock = n_q[2];
   // 32 bit clocks per word clock, word edge on a falling bit clock
   assign word_clock = n_q[7];
endmodule

//--- verification/sac_top_tb.sv
`timescale 1ns/10ps
module sac_top_tb;
   logic        clk, srst, psel, penable, pwrite, run, pready, pslverr, er, bclk, wclk;
   logic        src_ready, tx_sample_strobe, b2_out, b2_oe, w2_out, w2_oe;
   logic [1:0]  acnt;
   logic [6:0]  src_valid;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [39:0] smp, tx_sample;
   int          n_mismatch, comparisons, cyc;
   wire         audio_clk = acnt[1];
   wire         bpin = b2_oe ? b2_out : bclk;
   wire         wpin = w2_oe ? w2_out : wclk;
   sac_top i_sac_top (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .audio_clk, .p1_bit_clock(bclk), .p1_word_clock(wclk),
      .p2_bit_clock_in(bpin), .p2_bit_clock_out(b2_out), .p2_bit_clock_oe(b2_oe),
      .p2_word_clock_in(wpin), .p2_word_clock_out(w2_out), .p2_word_clock_oe(w2_oe),
      .p3_bit_clock_in(bclk), .p3_bit_clock_out(), .p3_bit_clock_oe(),
      .p3_word_clock_in(wclk), .p3_word_clock_out(), .p3_word_clock_oe(),
      .adc_bit_clock_in(bclk), .adc_bit_clock_out(), .adc_bit_clock_oe(),
      .p2_serial_bclk(), .p2_serial_wclk(), .p3_serial_bclk(), .p3_serial_wclk(),
      .p2_right_justified_format(), .p3_right_justified_format(), .p2_frame_bits(),
      .p3_frame_bits(), .p3_correction_flag_input_early(), .p1_error_flag_insert(1'b0),
      .p1_correction_flag_input_early(1'b0), .correction_flag_input(1'b0), .error_flag_input(1'b0),
      .cpu_audio_out_1(smp), .cpu_audio_out_2(smp), .cpu_audio_out_3(smp),
      .port1_rx_data(smp), .port3_rx_data(smp), .spdif_rx1_data(smp),
      .spdif_rx2_data(smp), .src_valid, .src_ready, .tx_sample, .tx_sample_strobe);
   sac_conv_model i_sac_conv_model (.clk, .run, .bit_clock(bclk), .word_clock(wclk));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      acnt <= acnt + 2'h1;
      cyc <= cyc + 1;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_strobe;
      do @(negedge clk);
      while (tx_sample_strobe !== 1'b1);
   endtask
   task automatic rise;
      logic b;
      do begin
         b = b2_out;
         @(negedge clk);
      end while (!(b === 1'b0 && b2_out === 1'b1));
   endtask
   task automatic t_regs;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'h14 + 8'(4 * i), '0);
         chk(rd, 32'h0000_0fc8);
      end
      apb(1'b1, 8'h1c, 32'ha5a5_0a5a);
      apb(1'b0, 8'h1c, '0);
      chk(rd, 32'ha5a5_0a5a);
      apb(1'b0, 8'h20, '0);
      chk({er, rd}, 33'h1_0000_0000);
   endtask
   task automatic t_fifo;
      logic [39:0] q [$];
      apb(1'b1, 8'h14, 32'h0000_0900);
      apb(1'b1, 8'h14, 32'h0000_0100);
      src_valid <= 7'h01;
      repeat (20) begin
         @(negedge clk);
         if (src_ready === 1'b1) q.push_back(smp);
         @(posedge clk);
         smp <= smp + 40'h11_1111_1111;
      end
      src_valid <= 7'h00;
      chk(q.size(), 8);
      run <= 1'b1;
      foreach (q[k]) begin
         wait_strobe();
         chk(tx_sample, q[k] & 40'hff_ff0f_fff0);
      end
      apb(1'b1, 8'h14, 32'h0000_01c0);
      repeat (2) wait_strobe();
      chk(tx_sample, '0);
   endtask
   task automatic t_div;
      logic [3:0] code [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'h8, 4'hb, 4'h0};
      int         div [11] = '{24, 16, 12, 8, 6, 4, 3, 2, 0, 0, 0};
      int         c0;
      apb(1'b1, 8'h14, 32'h0000_0900);
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, 8'h14, {16'h0000, code[i], 12'h900});
         repeat (200) @(negedge clk);
         chk(b2_oe, i < 9);
         if (div[i] > 0) begin
            rise();
            c0 = cyc;
            rise();
            chk(cyc - c0, 4 * div[i]);
         end
      end
   endtask
   task automatic final_report;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, run, acnt, paddr, pwdata, src_valid} = '0;
      {cyc, n_mismatch, comparisons} = '0;
      srst = 1'b1;
      smp = 40'h12_3456_789a;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_fifo();
      t_div();
      final_report();
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule
